// File: core/baud_clock_generator.sv
/*
  Baud clock generator with prescaler, baud divider, after-scaler, clock
  output selection, transmit data resync and the serial register block.
  Assumes clk is the reference clock; pa_on, tx_active, sync_sel,
  transparent_sel and tx_data_in come from the transmit state machine on clk;
  sck, en and sdio are pins and are synchronised here.
*/
`timescale 1ns/10ps
`include "baud_clock_defs.svh"
module baud_clock_generator
  import baud_clock_pkg::*;
#(
  parameter int SLEEP_CLOCKS = `SLEEP_CLOCKS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic en,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic pa_on,
  input wire logic tx_active,
  input wire logic sync_sel,
  input wire logic transparent_sel,
  input wire logic tx_data_in,
  output logic clock_output_pin,
  output logic clock_output_oe,
  output logic transmit_data_output,
  output logic data_gen_tick,
  output logic xtal_run,
  output tx_ctrl_t transmitter_control
);

  // pin synchronisers
  logic sck_q1_r, sck_q2_r, en_q1_r, en_q2_r, sdi_q1_r, sdi_q2_r;
  logic sck_d_r, en_d_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {sck_q1_r, sck_q2_r, en_q1_r, en_q2_r, sdi_q1_r, sdi_q2_r} <= 6'h00;
      {sck_d_r, en_d_r} <= 2'h0;
    end else begin
      {sck_q1_r, sck_q2_r} <= {sck, sck_q1_r};
      {en_q1_r, en_q2_r} <= {en, en_q1_r};
      {sdi_q1_r, sdi_q2_r} <= {sdio_in, sdi_q1_r};
      {sck_d_r, en_d_r} <= {sck_q2_r, en_q2_r};
    end
  end

  wire sck_rise = sck_q2_r & ~sck_d_r;
  wire sck_fall = ~sck_q2_r & sck_d_r;
  wire en_rise = en_q2_r & ~en_d_r;
  wire en_fall = ~en_q2_r & en_d_r;

  // serial link
  link_state_t state_r;
  logic edge_rise_r, rd_r;
  logic [2:0] bit_cnt_r;
  logic [`REG_ADDR_W-1:0] addr_r;
  logic [7:0] rx_shift_r, tx_shift_r;
  logic [1:0] load_p_r;
  tx_ctrl_t txctl_r;
  logic [7:0] baud_div_r;
  scaler_sel_t scaler_r;
  logic [7:0] mem_rdata;

  wire active_edge = en_q2_r & en_d_r & (state_r != LINK_IDLE)
                   & (edge_rise_r ? sck_rise : sck_fall);
  wire [7:0] rx_nxt = {rx_shift_r[6:0], sdi_q2_r};
  wire byte_done = active_edge & (bit_cnt_r == 3'h7);
  wire addr_ok = int'(addr_r) < `REG_COUNT;
  wire wr_strobe = byte_done & (state_r == LINK_DATA) & ~rd_r & addr_ok;
  wire wr_txctl = wr_strobe & (addr_r == `TRANSMITTER_CONTROL_ADDR);
  wire wr_baud = wr_strobe & (addr_r == `BAUD_DIVIDER_SELECT_ADDR);
  wire wr_scaler = wr_strobe & (addr_r == `SCALER_SELECT_ADDR);
  wire rd_start = byte_done & ((state_r == LINK_CMD) ? rx_nxt[`CMD_READ_BIT] : rd_r);
  wire [7:0] rd_byte = (addr_r == `TRANSMITTER_CONTROL_ADDR) ? txctl_r
                     : (addr_r == `BAUD_DIVIDER_SELECT_ADDR) ? baud_div_r
                     : (addr_r == `SCALER_SELECT_ADDR) ? scaler_r
                     : addr_ok ? mem_rdata : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= LINK_IDLE;
      edge_rise_r <= 1'b0;
      rd_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      addr_r <= '0;
      rx_shift_r <= 8'h00;
    end else if (en_rise) begin
      state_r <= LINK_CMD;
      edge_rise_r <= sck_q2_r;
      rd_r <= 1'b0;
      bit_cnt_r <= 3'h0;
    end else if (en_fall) begin
      state_r <= LINK_IDLE;
      rd_r <= 1'b0;
    end else if (active_edge) begin
      rx_shift_r <= rx_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && state_r == LINK_CMD) begin
        state_r <= LINK_DATA;
        rd_r <= rx_nxt[`CMD_READ_BIT];
        addr_r <= rx_nxt[`CMD_ADDR_MSB:0];
      end else if (byte_done) begin
        addr_r <= addr_r + 5'h01;
      end
    end
  end

  // read path: store output lags the address by one clock, hence two stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_p_r <= 2'h0;
      tx_shift_r <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      load_p_r <= {load_p_r[0], rd_start};
      if (load_p_r[1]) begin
        tx_shift_r <= rd_byte;
      end else if (active_edge) begin
        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
      sdio_out <= tx_shift_r[7];
      sdio_oe <= en_q2_r & rd_r & (state_r == LINK_DATA);
    end
  end

  cfg_byte_store #(
    .DEPTH(`REG_COUNT),
    .WIDTH(8),
    .AW(`REG_ADDR_W)
  ) u_store (
    .clk(clk),
    .wr_en(wr_strobe),
    .wr_addr(addr_r),
    .wr_data(rx_nxt),
    .rd_addr(addr_r),
    .rd_data_r(mem_rdata)
  );

  // enable-low timeout and control registers
  logic [`SLEEP_CNT_W-1:0] sleep_cnt_r;
  wire sleep_hit = ~en_q2_r & (sleep_cnt_r == `SLEEP_CNT_W'(SLEEP_CLOCKS - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_cnt_r <= '0;
    end else if (en_q2_r) begin
      sleep_cnt_r <= '0;
    end else if (!sleep_hit && !txctl_r.power_down_bit) begin
      sleep_cnt_r <= sleep_cnt_r + `SLEEP_CNT_W'(1);
    end
  end

  tx_ctrl_t txctl_nxt;
  always_comb begin
    txctl_nxt = wr_txctl ? tx_ctrl_t'(rx_nxt) : txctl_r;
    if (sleep_hit) begin
      txctl_nxt.power_down_bit = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txctl_r <= `TRANSMITTER_CONTROL_RESET;
      baud_div_r <= `BAUD_DIVIDER_SELECT_RESET;
      scaler_r <= `SCALER_SELECT_RESET;
    end else begin
      txctl_r <= txctl_nxt;
      if (wr_baud) begin
        baud_div_r <= rx_nxt;
      end
      if (wr_scaler) begin
        scaler_r <= rx_nxt;
      end else if (en_rise && !sdi_q2_r) begin
        scaler_r.prescaler_code <= `PRESCALER_STRAP_CODE;
      end
    end
  end

  // prescaler
  wire osc_on = ~txctl_r.power_down_bit;
  logic [6:0] presc_cnt_r;
  logic presc_level_r;
  wire [6:0] presc_mask = 7'((8'h01 << scaler_r.prescaler_code) - 8'h01);
  wire presc_tick = osc_on & ((presc_cnt_r & presc_mask) == presc_mask);
  wire [6:0] presc_cnt_nxt = presc_cnt_r + 7'h01;
  wire [2:0] presc_bit = scaler_r.prescaler_code - 3'h1;
  wire presc_level_nxt = (scaler_r.prescaler_code == 3'h0) ? ~presc_level_r
                       : presc_cnt_nxt[presc_bit];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_cnt_r <= 7'h00;
      presc_level_r <= 1'b0;
    end else if (osc_on) begin
      presc_cnt_r <= presc_cnt_nxt;
      presc_level_r <= presc_level_nxt;
    end
  end

  // baud divider and after-scaler
  logic [7:0] baud_cnt_r;
  logic baud_r;
  logic [2:0] asc_cnt_r;
  wire baud_wrap = presc_tick & (baud_cnt_r == baud_div_r);
  wire baud_rise = baud_wrap & ~baud_r;
  wire asc_run = pa_on & tx_active;
  wire [2:0] asc_mask = 3'((4'h1 << scaler_r.after_scaler_code) - 4'h1);
  wire asc_hit = baud_rise & asc_run & ((asc_cnt_r & asc_mask) == asc_mask);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      baud_cnt_r <= 8'h00;
      baud_r <= 1'b0;
      asc_cnt_r <= 3'h0;
      data_gen_tick <= 1'b0;
    end else if (!pa_on) begin
      baud_cnt_r <= 8'h00;
      baud_r <= 1'b0;
      asc_cnt_r <= 3'h0;
      data_gen_tick <= 1'b0;
    end else begin
      if (presc_tick) begin
        baud_cnt_r <= baud_wrap ? 8'h00 : baud_cnt_r + 8'h01;
      end
      if (baud_wrap) begin
        baud_r <= ~baud_r;
      end
      if (baud_rise && asc_run) begin
        asc_cnt_r <= asc_cnt_r + 3'h1;
      end
      data_gen_tick <= asc_hit;
    end
  end

  // clock output selection; the pin sees the baud clock before after-scaling
  wire [1:0] csrc = scaler_r.clock_source_code[1:0];
  wire csrc_top = scaler_r.clock_source_code[2];
  wire src_live = (csrc == `CSRC_LOW) ? 1'b0
                : (csrc == `CSRC_PRESCALER) ? presc_level_r
                : (csrc == `CSRC_BAUD) ? baud_r : ~baud_r;
  wire src_idle = csrc_top & (csrc == `CSRC_BAUD_INV);
  wire ck_val = (tx_active || (csrc_top && csrc == `CSRC_PRESCALER)) ? src_live : src_idle;
  wire ck_oe = ~txctl_r.clock_out_power_down & (csrc_top | tx_active);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_output_pin <= 1'b0;
      clock_output_oe <= 1'b0;
    end else begin
      clock_output_pin <= ck_val;
      clock_output_oe <= ck_oe;
    end
  end

  // transmit data: always re-timed here, even when passed through from the pin
  wire data_src = transparent_sel ? sdi_q2_r : tx_data_in;
  wire ck_edge = (csrc == `CSRC_BAUD_INV) ? (~ck_val & clock_output_pin)
               : (ck_val & ~clock_output_pin);
  wire txd_nxt = (sync_sel && !ck_edge) ? transmit_data_output : data_src;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      transmit_data_output <= 1'b0;
      xtal_run <= 1'b0;
      transmitter_control <= `TRANSMITTER_CONTROL_RESET;
    end else begin
      transmit_data_output <= txd_nxt;
      xtal_run <= osc_on;
      transmitter_control <= txctl_r;
    end
  end

  // checks
  chk_baud_held_off: assert property (@(posedge clk) disable iff (!resetn)
    !pa_on |=> (baud_cnt_r == 8'h00) && !baud_r && (asc_cnt_r == 3'h0))
    else $error("baud counter not held while amplifier off");

  chk_baud_toggle: assert property (@(posedge clk) disable iff (!resetn)
    pa_on && presc_tick && (baud_cnt_r == baud_div_r) |=> baud_r != $past(baud_r))
    else $error("baud clock did not toggle at divider wrap");

  chk_presc_runs: assert property (@(posedge clk) disable iff (!resetn)
    osc_on |=> presc_cnt_r == $past(presc_cnt_r) + 7'h01)
    else $error("prescaler stalled while oscillator runs");

  chk_presc_strap: assert property (@(posedge clk) disable iff (!resetn)
    en_rise && !sdi_q2_r |=> scaler_r.prescaler_code == `PRESCALER_STRAP_CODE)
    else $error("prescaler strap not applied");

  chk_clock_output_pin_pd: assert property (@(posedge clk) disable iff (!resetn)
    txctl_r.clock_out_power_down |=> !clock_output_oe)
    else $error("clock pin driven while powered down");

  chk_clock_output_pin_idle: assert property (@(posedge clk) disable iff (!resetn)
    !csrc_top && !tx_active |=> !clock_output_oe)
    else $error("clock pin driven while idle with top bit clear");

  chk_clock_output_pin_high_idle: assert property (@(posedge clk) disable iff (!resetn)
    scaler_r.clock_source_code == 3'h7 && !tx_active && !txctl_r.clock_out_power_down
    |=> clock_output_oe && clock_output_pin)
    else $error("clock pin not high when idle on inverted code");

  chk_asc_idle: assert property (@(posedge clk) disable iff (!resetn)
    !asc_run |=> !data_gen_tick)
    else $error("data tick while not transmitting");

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
    sleep_hit |=> txctl_r.power_down_bit ##1 !xtal_run)
    else $error("power-down not entered after enable timeout");

  chk_txctl_commit: assert property (@(posedge clk) disable iff (!resetn)
    wr_txctl && !sleep_hit |=> txctl_r == $past(rx_nxt))
    else $error("control byte not applied whole");

endmodule : baud_clock_generator

// File: core/cfg_byte_store.sv
/*
  Small byte store holding the configuration block; read data is registered.
  Assumes one clock, one write port and one read port with one cycle latency.
*/
`timescale 1ns/10ps
module cfg_byte_store #(
  parameter int DEPTH = 20,
  parameter int WIDTH = 8,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_r
);

  // contents survive reset on purpose: only software rewrites them
  logic [WIDTH-1:0] mem [DEPTH];

  wire wr_ok = wr_en && (int'(wr_addr) < DEPTH);
  wire rd_ok = int'(rd_addr) < DEPTH;

  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= rd_ok ? mem[rd_addr] : '0;
  end

endmodule : cfg_byte_store

// File: pkg/baud_clock_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the baud clock
  generator and its serially configured register block.
  Assumes it is included by bare name from design files that need the numbers.
*/
`ifndef BAUD_CLOCK_DEFS_SVH
`define BAUD_CLOCK_DEFS_SVH

// register block
`define REG_COUNT 20
`define REG_ADDR_W 5
`define TRANSMITTER_CONTROL_ADDR 5'h0e
`define BAUD_DIVIDER_SELECT_ADDR 5'h0f
`define SCALER_SELECT_ADDR 5'h10

// first byte of a frame: direction flag and address field
`define CMD_READ_BIT 7
`define CMD_ADDR_MSB 4

// reset values
`define TRANSMITTER_CONTROL_RESET 8'h00
`define BAUD_DIVIDER_SELECT_RESET 8'h00
`define SCALER_SELECT_RESET 8'hb0

// prescaler code forced by the strap at an enable rising edge
`define PRESCALER_STRAP_CODE 3'h4

// clock source codes
`define CSRC_LOW 2'h0
`define CSRC_PRESCALER 2'h1
`define CSRC_BAUD 2'h2
`define CSRC_BAUD_INV 2'h3

// enable-low time before power-down, in reference clock cycles
`define SLEEP_CLOCKS 65536
`define SLEEP_CNT_W 17

`endif

// File: pkg/baud_clock_pkg.sv
/*
  Types shared by the baud clock generator: register layouts and the
  serial link state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package baud_clock_pkg;

  typedef struct packed {
    logic power_down_bit;
    logic clock_out_power_down;
    logic xtal_div;
    logic fb_sel;
    logic [1:0] pa_mode;
    logic ref_ext;
    logic pll_enable_bit;
  } tx_ctrl_t;

  typedef struct packed {
    logic [2:0] clock_source_code;
    logic [2:0] prescaler_code;
    logic [1:0] after_scaler_code;
  } scaler_sel_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_CMD = 2'b01,
    LINK_DATA = 2'b10
  } link_state_t;

endpackage : baud_clock_pkg

// File: tb/baud_clock_generator_test.sv
/*
  Self-checking bench for the baud clock generator and its register block.
  Assumes cfg_host_model drives the serial link at the reference clock.
*/
`timescale 1ns/10ps
`include "baud_clock_defs.svh"
`define CHECK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module baud_clock_generator_test
  import baud_clock_pkg::*;
;
  // short enable-low timeout keeps the power-down case cheap to reach
  localparam int SLEEP = 3000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic noise_r = 1'b0;
  logic pa_on = 1'b0;
  logic tx_active = 1'b0;
  logic sync_sel = 1'b0;
  logic transparent_sel = 1'b0;
  logic tx_data_in = 1'b0;
  logic sck, en, sdio_drv, host_oe, sdio_wire, sdio_out, sdio_oe;
  logic ck_pin, ck_oe, txd, tick, xtal_run;
  tx_ctrl_t tc;
  int failures = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) noise_r <= ~noise_r;
  // a released line shows a changing pattern, not its last value
  assign sdio_wire = sdio_oe ? sdio_out : (host_oe ? sdio_drv : noise_r);
  cfg_host_model host (.clk(clk), .sdio_wire(sdio_wire), .sck(sck), .en(en),
    .sdio_drv(sdio_drv), .sdio_host_oe(host_oe));
  baud_clock_generator #(.SLEEP_CLOCKS(SLEEP)) DUT (.clk(clk), .resetn(resetn), .sck(sck),
    .en(en), .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .pa_on(pa_on),
    .tx_active(tx_active), .sync_sel(sync_sel), .transparent_sel(transparent_sel),
    .tx_data_in(tx_data_in), .clock_output_pin(ck_pin), .clock_output_oe(ck_oe),
    .transmit_data_output(txd), .data_gen_tick(tick), .xtal_run(xtal_run),
    .transmitter_control(tc));
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.data_q[0] = d;
    host.frame(1'b1, 1'b0, {3'h0, a}, 1);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic strap);
    host.frame(1'b1, strap, {3'h4, a}, 1);
  endtask : rd
  // cycles between two rising samples; 0 if fewer than two rises come
  task automatic gap(input logic use_tick, output int n);
    logic p;
    logic c;
    int e;
    p = 1'b1;
    e = 0;
    n = 0;
    repeat (1000) begin
      @(negedge clk);
      c = use_tick ? tick : ck_pin;
      if (e == 1) n++;
      if (c && !p) e++;
      p = c;
      if (e == 2) break;
    end
    if (e < 2) n = 0;
  endtask : gap
  task automatic changes(output int n);
    logic p;
    @(negedge clk);
    p = ck_pin;
    n = 0;
    repeat (48) begin
      @(negedge clk);
      if (ck_pin !== p) n++;
      p = ck_pin;
    end
  endtask : changes
  task automatic test_reset();
    host.frame(1'b1, 1'b0, 8'h8e, 3);
    `CHECK("reset 0e", `TRANSMITTER_CONTROL_RESET, host.data_q[0])
    `CHECK("reset 0f", `BAUD_DIVIDER_SELECT_RESET, host.data_q[1])
    `CHECK("reset 10", `SCALER_SELECT_RESET, host.data_q[2])
  endtask : test_reset
  task automatic test_block();
    for (int i = 0; i < 3; i++) host.data_q[i] = 8'h3c ^ 8'(i * 37);
    host.frame(1'b0, 1'b0, 8'h11, 3);
    for (int i = 0; i < 3; i++) begin
      host.frame(1'b0, 1'b0, 8'h91 + 8'(i), 1);
      `CHECK("stored byte", 8'h3c ^ 8'(i * 37), host.data_q[0])
    end
    wr(5'h14, 8'h5a);
    rd(5'h14, 1'b0);
    `CHECK("unmapped", 8'h00, host.data_q[0])
  endtask : test_block
  task automatic test_presc();
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(`SCALER_SELECT_ADDR, {3'h5, 3'(c), 2'h0});
      gap(1'b0, n);
      `CHECK("presc period", (c == 0) ? 2 : (1 << c), n)
    end
  endtask : test_presc
  task automatic test_baud();
    int n;
    wr(`BAUD_DIVIDER_SELECT_ADDR, 8'h02);
    @(posedge clk);
    pa_on <= 1'b1;
    tx_active <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      wr(`SCALER_SELECT_ADDR, {3'h6, 3'h3, 2'(a)});
      gap(1'b0, n);
      `CHECK("baud period", 2 * (2 + 1) * 8, n)
      gap(1'b1, n);
      `CHECK("tick period", (2 * (2 + 1) * 8) << a, n)
    end
    @(posedge clk);
    tx_active <= 1'b0;
    gap(1'b1, n);
    `CHECK("no tick idle", 0, n)
    @(posedge clk);
    pa_on <= 1'b0;
    tx_active <= 1'b1;
    // let the last baud level drain out of the pin register first
    wait_n(4);
    changes(n);
    `CHECK("baud held", 0, n)
    `CHECK("baud level", 1'b0, ck_pin)
  endtask : test_baud
  task automatic test_css();
    logic oe;
    logic run;
    int n;
    @(posedge clk);
    pa_on <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(`SCALER_SELECT_ADDR, {3'(c), 5'h00});
      for (int t = 0; t < 2; t++) begin
        @(posedge clk);
        tx_active <= 1'(t);
        wait_n(8);
        oe = c[2] | t[0];
        run = oe && (c[1:0] == 1 || (c[1:0] >= 2 && t == 1));
        changes(n);
        `CHECK("pin oe", oe, ck_oe)
        `CHECK("pin runs", run, n > 0)
        if (oe && !run) `CHECK("pin level", c == 7 && t == 0, ck_pin)
      end
    end
    wr(`TRANSMITTER_CONTROL_ADDR, 8'h40);
    wait_n(8);
    `CHECK("pin off", 1'b0, ck_oe)
    wr(`TRANSMITTER_CONTROL_ADDR, 8'h00);
  endtask : test_css
  task automatic test_txd();
    @(posedge clk);
    pa_on <= 1'b0;
    tx_data_in <= 1'b1;
    wait_n(6);
    `CHECK("txd gen", 1'b1, txd)
    @(posedge clk);
    transparent_sel <= 1'b1;
    tx_data_in <= 1'b0;
    wait_n(6);
    `CHECK("txd transparent", 1'b1, txd)
    @(posedge clk);
    transparent_sel <= 1'b0;
    sync_sel <= 1'b1;
    wait_n(20);
    `CHECK("txd waits edge", 1'b1, txd)
    @(posedge clk);
    pa_on <= 1'b1;
    wait_n(200);
    `CHECK("txd on edge", 1'b0, txd)
    wr(`SCALER_SELECT_ADDR, 8'hc0);
    @(posedge clk);
    pa_on <= 1'b0;
    // pin must settle low before the data changes, or a late rise takes it
    wait_n(4);
    @(posedge clk);
    tx_data_in <= 1'b1;
    wait_n(20);
    `CHECK("txd waits rise", 1'b0, txd)
    @(posedge clk);
    pa_on <= 1'b1;
    wait_n(200);
    `CHECK("txd on rise", 1'b1, txd)
  endtask : test_txd
  task automatic test_strap();
    wr(`SCALER_SELECT_ADDR, 8'hbc);
    rd(`SCALER_SELECT_ADDR, 1'b0);
    `CHECK("no strap", 8'hbc, host.data_q[0])
    rd(`SCALER_SELECT_ADDR, 1'b1);
    `CHECK("strap", {3'h5, `PRESCALER_STRAP_CODE, 2'h0}, host.data_q[0])
  endtask : test_strap
  task automatic test_sleep();
    wait_n(SLEEP + 8);
    `CHECK("pd bit", 1'b1, tc.power_down_bit)
    `CHECK("xtal off", 1'b0, xtal_run)
    rd(`BAUD_DIVIDER_SELECT_ADDR, 1'b0);
    `CHECK("kept", 8'h02, host.data_q[0])
    wr(`TRANSMITTER_CONTROL_ADDR, 8'h81);
    wait_n(2);
    `CHECK("mode byte", 8'h81, tc)
    wr(`TRANSMITTER_CONTROL_ADDR, 8'h01);
    wait_n(4);
    `CHECK("mode clear", 8'h01, tc)
    `CHECK("xtal on", 1'b1, xtal_run)
  endtask : test_sleep
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    wait_n(4);
    test_reset();
    test_block();
    test_presc();
    test_baud();
    test_css();
    test_txd();
    test_strap();
    test_sleep();
    give_verdict();
  end
  // full run is near 18k cycles; this allows over three times that
  initial begin
    #600_000;
    failures++;
    give_verdict();
  end
endmodule : baud_clock_generator_test

// File: tb/cfg_host_model.sv
/*
  Host side of the serial configuration link: frames of a command byte and data bytes.
  Assumes clk is the device reference clock and the bench resolves the data wire.
*/
`timescale 1ns/10ps
module cfg_host_model (
  input wire logic clk,
  input wire logic sdio_wire,
  output logic sck,
  output logic en,
  output logic sdio_drv,
  output logic sdio_host_oe
);
  logic [7:0] data_q [4];
  initial begin
    sck = 1'b1;
    en = 1'b0;
    sdio_drv = 1'b1;
    sdio_host_oe = 1'b1;
  end
  // act is the sck level at enable rise, which picks the active edge
  task automatic frame(input logic act, input logic strap, input logic [7:0] cmd,
                       input int n);
    logic [7:0] sh;
    sh = cmd;
    @(posedge clk);
    sck <= act;
    sdio_drv <= ~strap;
    repeat (4) @(posedge clk);
    en <= 1'b1;
    repeat (8) @(posedge clk);
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        // data moves on the inactive edge so it is settled for the active one
        sck <= ~act;
        sdio_host_oe <= (b == 0) || !cmd[7];
        sdio_drv <= sh[i];
        repeat (8) @(posedge clk);
        if (b > 0 && cmd[7]) sh[i] = sdio_wire;
        sck <= act;
        repeat (8) @(posedge clk);
      end
      if (b > 0) data_q[b-1] = sh;
      if (b < n) sh = data_q[b];
    end
    en <= 1'b0;
    sdio_host_oe <= 1'b1;
    sdio_drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : cfg_host_model
